// ===== dbt_pkg.sv
// constants and types for the debug trigger and run status logic
package dbt_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_TRIG   = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_FIFO_H = 5'h0c;
	localparam logic [4:0] OFS_FIFO_L = 5'h10;

	// ------------------------------------------------------------
	// debug_control_reg fields
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT    = 7;
	localparam int CTRL_ARM_BIT   = 6;
	localparam int CTRL_TAG_BIT   = 5;
	localparam int CTRL_BREAK_BIT = 4;
	localparam logic [7:0] CTRL_RW_MASK = 8'h0f;

	// ------------------------------------------------------------
	// trigger_config fields
	// ------------------------------------------------------------
	localparam int TRIG_SEL_BIT   = 7;
	localparam int TRIG_BEGIN_BIT = 6;
	localparam logic [7:0] TRIG_WR_MASK = 8'hcf;
	localparam logic [7:0] TRIG_RESET   = 8'h00;

	// ------------------------------------------------------------
	// run_status fields
	// ------------------------------------------------------------
	localparam int STAT_HIT_A_BIT = 7;
	localparam int STAT_HIT_B_BIT = 6;
	localparam int STAT_ARMED_BIT = 5;

	// ------------------------------------------------------------
	// trigger mode codes
	// ------------------------------------------------------------
	localparam logic [3:0] MODE_A_ONLY    = 4'h0;
	localparam logic [3:0] MODE_A_OR_B    = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B  = 4'h2;
	localparam logic [3:0] MODE_EVT_B     = 4'h3;
	localparam logic [3:0] MODE_A_EVT_B   = 4'h4;
	localparam logic [3:0] MODE_A_AND_B   = 4'h5;
	localparam logic [3:0] MODE_A_NAND_B  = 4'h6;
	localparam logic [3:0] MODE_INSIDE    = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE   = 4'h8;

	// ------------------------------------------------------------
	// axi responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		st_idle,
		st_wait,
		st_capture
	} dbt_state_t;

endpackage : dbt_pkg

// ===== dbt_top.sv
// debug trigger selection, trace storage and run status behind an axi4-lite slave
`timescale 1ns/1ns
module dbt_top #(
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// comparator and bus tracking side
	input  wire logic        bus_cycle,
	input  wire logic        opcode_exec,
	input  wire logic        comp_a_match,
	input  wire logic        comp_b_match,
	input  wire logic        comp_b_data_match,
	input  wire logic        addr_below_a,
	input  wire logic        addr_above_b,
	input  wire logic [15:0] trace_word,
	input  wire logic        mcu_secure,
	// cpu break request
	output logic             cpu_break_req,
	output logic             cpu_break_tag
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]         ctrl_ff;
	logic [7:0]         trig_ff;
	logic               hit_a_ff;
	logic               hit_b_ff;
	logic               a_seen_ff;
	logic [3:0]         cnt_ff;
	logic [2:0]         wptr_ff;
	logic [2:0]         rptr_ff;
	logic [15:0]        mem_ff [DEPTH];
	dbt_pkg::dbt_state_t state_ff;
	logic               aw_got_ff;
	logic               w_got_ff;
	logic [4:0]         awaddr_ff;
	logic [7:0]         wdata_ff;
	logic               wlane_ff;
	logic               brk_ff;

	// ------------------------------------------------------------
	// decoded controls
	// ------------------------------------------------------------
	logic       en;
	logic       armed;
	logic       tag_sel;
	logic       evt_only;
	logic       begin_eff;
	logic [3:0] mode;
	logic       qual;
	logic       a_evt;
	logic       b_evt;
	logic       trig_evt;
	logic       store_evt;
	logic       store_en;
	logic       full_end;
	logic       trig_end;
	logic       run_done;
	logic       do_wr;
	logic       ctrl_wr;
	logic       trig_wr;
	logic       run_start;
	logic       nxt_en;
	logic       rd_take;
	logic       fifo_l_rd;

	assign en       = ctrl_ff[dbt_pkg::CTRL_EN_BIT];
	assign armed    = ctrl_ff[dbt_pkg::CTRL_ARM_BIT];
	assign tag_sel  = trig_ff[dbt_pkg::TRIG_SEL_BIT];
	assign mode     = trig_ff[3:0];
	assign evt_only = (mode == dbt_pkg::MODE_EVT_B) || (mode == dbt_pkg::MODE_A_EVT_B);
	// event-only runs ignore the begin bit
	assign begin_eff = evt_only | trig_ff[dbt_pkg::TRIG_BEGIN_BIT];

	// tag waits for the opcode to execute, force takes any access
	assign qual  = tag_sel ? opcode_exec : bus_cycle;
	assign a_evt = comp_a_match & qual;
	assign b_evt = comp_b_match & qual;

	// ------------------------------------------------------------
	// trigger mode decode
	// ------------------------------------------------------------
	always_comb begin
		trig_evt = 1'b0;
		unique case (mode)
			dbt_pkg::MODE_A_ONLY:   trig_evt = a_evt;
			dbt_pkg::MODE_A_OR_B:   trig_evt = a_evt | b_evt;
			dbt_pkg::MODE_A_THEN_B: trig_evt = a_seen_ff & b_evt;
			dbt_pkg::MODE_A_AND_B:  trig_evt = a_evt & comp_b_data_match;
			dbt_pkg::MODE_A_NAND_B: trig_evt = a_evt & ~comp_b_data_match;
			dbt_pkg::MODE_INSIDE:   trig_evt = qual & ~addr_below_a & ~addr_above_b;
			dbt_pkg::MODE_OUTSIDE:  trig_evt = qual & (addr_below_a | addr_above_b);
			default:                trig_evt = 1'b0;
		endcase
	end

	// event-only modes store on B events instead of every bus cycle
	assign store_evt = (mode == dbt_pkg::MODE_EVT_B)   ? b_evt :
	                   (mode == dbt_pkg::MODE_A_EVT_B) ? (a_seen_ff & b_evt) :
	                   bus_cycle;
	assign store_en  = armed && (state_ff == dbt_pkg::st_capture) && store_evt;
	assign full_end  = begin_eff && store_en && (cnt_ff == 4'(DEPTH - 1));
	assign trig_end  = armed && !begin_eff && trig_evt;
	assign run_done  = full_end | trig_end;

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	assign do_wr   = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	assign ctrl_wr = do_wr && wlane_ff && (awaddr_ff == dbt_pkg::OFS_CTRL);
	assign trig_wr = do_wr && wlane_ff && (awaddr_ff == dbt_pkg::OFS_TRIG) && !armed;
	// a secure part keeps the enable from rising
	assign nxt_en  = wdata_ff[dbt_pkg::CTRL_EN_BIT] & (en | ~mcu_secure);
	assign run_start = ctrl_wr && !armed && nxt_en && wdata_ff[dbt_pkg::CTRL_ARM_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff     <= 1'b0;
			awaddr_ff     <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_ff     <= 1'b1;
			awaddr_ff     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_wr) begin
			aw_got_ff <= 1'b0;
		end else if (!aw_got_ff && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_ff     <= 1'b0;
			wdata_ff     <= '0;
			wlane_ff     <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_ff     <= 1'b1;
			wdata_ff     <= s_axi_wdata[7:0];
			wlane_ff     <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (do_wr) begin
			w_got_ff <= 1'b0;
		end else if (!w_got_ff && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dbt_pkg::RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			// status and trace ports answer okay but ignore the data
			s_axi_bresp  <= (awaddr_ff > dbt_pkg::OFS_FIFO_L || awaddr_ff[1:0] != 2'h0)
			                ? dbt_pkg::RESP_DECERR : dbt_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// control register and arming
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= 8'h00;
		end else if (ctrl_wr) begin
			ctrl_ff[dbt_pkg::CTRL_EN_BIT]  <= nxt_en;
			// a run end in the same cycle wins over a write that keeps the arm bit set
			ctrl_ff[dbt_pkg::CTRL_ARM_BIT] <= nxt_en & wdata_ff[dbt_pkg::CTRL_ARM_BIT] &
			                                  (run_start | ~run_done);
			ctrl_ff[3:0] <= wdata_ff[3:0] & dbt_pkg::CTRL_RW_MASK[3:0];
			ctrl_ff[dbt_pkg::CTRL_TAG_BIT]   <= wdata_ff[dbt_pkg::CTRL_TAG_BIT];
			ctrl_ff[dbt_pkg::CTRL_BREAK_BIT] <= wdata_ff[dbt_pkg::CTRL_BREAK_BIT];
		end else if (run_done) begin
			ctrl_ff[dbt_pkg::CTRL_ARM_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_ff <= dbt_pkg::TRIG_RESET;
		end else if (trig_wr) begin
			trig_ff <= wdata_ff & dbt_pkg::TRIG_WR_MASK;
		end
	end

	// ------------------------------------------------------------
	// run sequencing
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= dbt_pkg::st_idle;
		end else if (run_start) begin
			// end traces fill circularly from arming on
			state_ff <= (begin_eff && !evt_only) ? dbt_pkg::st_wait : dbt_pkg::st_capture;
		end else if (!armed || run_done) begin
			state_ff <= dbt_pkg::st_idle;
		end else if (state_ff == dbt_pkg::st_wait && trig_evt) begin
			state_ff <= dbt_pkg::st_capture;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_a_ff  <= 1'b0;
			hit_b_ff  <= 1'b0;
			a_seen_ff <= 1'b0;
		end else if (run_start) begin
			hit_a_ff  <= 1'b0;
			hit_b_ff  <= 1'b0;
			a_seen_ff <= 1'b0;
		end else if (armed) begin
			if (a_evt) begin
				hit_a_ff  <= 1'b1;
				a_seen_ff <= 1'b1;
			end
			if (b_evt) begin
				hit_b_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// trace storage
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= 4'h0;
			wptr_ff <= 3'h0;
		end else if (run_start) begin
			cnt_ff  <= 4'h0;
			wptr_ff <= 3'h0;
		end else if (store_en) begin
			wptr_ff <= wptr_ff + 3'h1;
			if (cnt_ff != 4'(DEPTH)) begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (store_en) begin
			// event-only words keep a zero high byte
			mem_ff[wptr_ff] <= evt_only ? {8'h00, trace_word[7:0]} : trace_word;
		end
	end

	// readout starts at the oldest word once the run stops
	assign rd_take   = s_axi_arvalid & s_axi_arready;
	assign fifo_l_rd = rd_take && (s_axi_araddr == dbt_pkg::OFS_FIFO_L) && !armed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rptr_ff <= 3'h0;
		end else if (run_start) begin
			rptr_ff <= 3'h0;
		end else if (armed && store_en && cnt_ff == 4'(DEPTH)) begin
			rptr_ff <= wptr_ff + 3'h1;
		end else if (fifo_l_rd) begin
			rptr_ff <= rptr_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// break request
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brk_ff        <= 1'b0;
			cpu_break_req <= 1'b0;
			cpu_break_tag <= 1'b0;
		end else begin
			brk_ff        <= ctrl_ff[dbt_pkg::CTRL_BREAK_BIT] & run_done;
			cpu_break_req <= ctrl_ff[dbt_pkg::CTRL_BREAK_BIT] & run_done;
			cpu_break_tag <= ctrl_ff[dbt_pkg::CTRL_TAG_BIT];
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= dbt_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= dbt_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			unique case (s_axi_araddr)
				dbt_pkg::OFS_CTRL:   s_axi_rdata[7:0] <= ctrl_ff;
				dbt_pkg::OFS_TRIG:   s_axi_rdata[7:0] <= trig_ff;
				dbt_pkg::OFS_STATUS: s_axi_rdata[7:0] <= {hit_a_ff, hit_b_ff, en & armed, 1'b0, cnt_ff};
				dbt_pkg::OFS_FIFO_H: s_axi_rdata[7:0] <= mem_ff[rptr_ff][15:8];
				dbt_pkg::OFS_FIFO_L: s_axi_rdata[7:0] <= mem_ff[rptr_ff][7:0];
				default:             s_axi_rresp      <= dbt_pkg::RESP_DECERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cfg_locked: assert property (armed && do_wr && awaddr_ff == dbt_pkg::OFS_TRIG |=> $stable(trig_ff))
		else $error("trigger config changed while armed");
	a_cfg_zero_bits: assert property (trig_ff[5:4] == 2'h0)
		else $error("trigger config bits 5:4 not zero");
	a_mode_none: assert property (mode > dbt_pkg::MODE_OUTSIDE |-> !trig_evt)
		else $error("reserved mode produced trigger");
	a_run_start_clear: assert property (run_start |=> !hit_a_ff && !hit_b_ff && cnt_ff == 4'h0 && armed)
		else $error("run start did not clear flags and count");
	a_end_trig_stop: assert property (trig_end && !ctrl_wr |=> !armed ##1 !armed)
		else $error("end trace trigger did not end run");
	a_full_stop: assert property (full_end && !ctrl_wr |=> !armed && cnt_ff == 4'(DEPTH))
		else $error("begin trace full did not end run");
	a_manual_stop: assert property (ctrl_wr && !wdata_ff[dbt_pkg::CTRL_ARM_BIT] |=> !armed)
		else $error("manual stop left run armed");
	a_cnt_hold: assert property (!armed && !ctrl_wr |=> $stable(cnt_ff))
		else $error("valid count moved while idle");
	a_break_pulse: assert property (run_done && ctrl_ff[dbt_pkg::CTRL_BREAK_BIT] |=> cpu_break_req)
		else $error("break request missing at run end");
	a_evt_high_zero: assert property (store_en && evt_only |=> mem_ff[$past(wptr_ff)][15:8] == 8'h00)
		else $error("event-only word has high byte");
	a_secure_en: assert property ($rose(en) |-> !$past(mcu_secure))
		else $error("enable set while secure");
	a_brk_once: assert property (brk_ff |=> !brk_ff || $past(run_done))
		else $error("break request not a pulse");

endmodule : dbt_top

// ===== dbt_cpu_model.sv
// processor bus and comparator model driving the trigger logic
`timescale 1ns/1ns
module dbt_cpu_model (
	// clock
	input  wire logic   aclk,
	// bus tracking outputs
	output logic        bus_cycle,
	output logic        opcode_exec,
	output logic        comp_a_match,
	output logic        comp_b_match,
	output logic        comp_b_data_match,
	output logic        addr_below_a,
	output logic        addr_above_b,
	output logic [15:0] trace_word
);
	initial begin
		bus_cycle = 1'b0;
		opcode_exec = 1'b0;
		{comp_a_match, comp_b_match, comp_b_data_match, addr_below_a, addr_above_b} = 5'h15;
		trace_word = 16'ha5c3;
	end

	// one access lasts one cycle; lines then flip so a stale hit never looks qualified
	task automatic access(input logic [4:0] v, input logic op, input logic [15:0] w);
		@(posedge aclk);
		bus_cycle <= 1'b1;
		opcode_exec <= op;
		{comp_a_match, comp_b_match, comp_b_data_match, addr_below_a, addr_above_b} <= v;
		trace_word <= w;
		@(posedge aclk);
		bus_cycle <= 1'b0;
		opcode_exec <= 1'b0;
		{comp_a_match, comp_b_match, comp_b_data_match, addr_below_a, addr_above_b} <= ~v;
		trace_word <= ~w;
	endtask : access
endmodule : dbt_cpu_model

// ===== dbt_top_bench.sv
// self-checking bench for the debug trigger and run status logic
`timescale 1ns/1ns
module dbt_top_bench;
	// ------------------------------------------------------------
	// signals and case tables
	// ------------------------------------------------------------
	logic        aclk, aresetn, mcu_secure, cpu_break_req, cpu_break_tag;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        bus_cycle, opcode_exec, comp_a_match, comp_b_match, comp_b_data_match;
	logic        addr_below_a, addr_above_b;
	logic [15:0] trace_word;
	logic [7:0]  rdv;
	logic [31:0] seed = 32'h29ab9319;
	int          fails = 0, n_checks = 0, breaks = 0;
	// end trace cases, vectors are {a, b, b data, below a, above b}; last one runs tagged
	logic [3:0]  md[8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h0};
	logic [4:0]  qv[8] = '{5'h00, 5'h00, 5'h08, 5'h10, 5'h1c, 5'h02, 5'h00, 5'h10};
	logic [4:0]  pv[8] = '{5'h00, 5'h00, 5'h10, 5'h10, 5'h1c, 5'h02, 5'h00, 5'h00};
	logic [4:0]  fv[8] = '{5'h10, 5'h08, 5'h08, 5'h1c, 5'h10, 5'h00, 5'h01, 5'h10};

	dbt_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .bus_cycle, .opcode_exec, .comp_a_match, .comp_b_match, .comp_b_data_match,
		.addr_below_a, .addr_above_b, .trace_word, .mcu_secure, .cpu_break_req, .cpu_break_tag);
	dbt_cpu_model cpu_u (.aclk, .bus_cycle, .opcode_exec, .comp_a_match, .comp_b_match,
		.comp_b_data_match, .addr_below_a, .addr_above_b, .trace_word);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk)
		if (cpu_break_req === 1'b1) breaks <= breaks + 1;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [7:0] st(input logic a, b, r, input logic [3:0] c);
		return {a, b, r, 1'b0, c};
	endfunction : st

	function automatic logic [1:0] exp_resp(input logic [4:0] a);
		return (a > dbt_pkg::OFS_FIFO_L) ? dbt_pkg::RESP_DECERR : dbt_pkg::RESP_OKAY;
	endfunction : exp_resp

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'(xs()), d};
		s_axi_wstrb <= {3'(xs()), 1'b1};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				check("write resp", s_axi_bresp, exp_resp(a));
				return;
			end
		end
		check("write wait", 1'b0, 1'b1);
		finish_test();
	endtask : wr

	task automatic rd(input logic [4:0] a);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rdv = s_axi_rdata[7:0];
				check("read resp", s_axi_rresp, exp_resp(a));
				return;
			end
		end
		check("read wait", 1'b0, 1'b1);
		finish_test();
	endtask : rd

	task automatic rchk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		rd(a);
		check($sformatf("reg %h", a), rdv & m, e & m);
	endtask : rchk

	task automatic acc(input logic [4:0] v, input logic op);
		cpu_u.access(v, op, 16'(xs()));
	endtask : acc

	// arm an end trace, stay quiet long enough to saturate the count, then fire
	task automatic end_run(input int i);
		logic [7:0] tg;
		tg = {i == 7, 3'h0, md[i]};
		wr(dbt_pkg::OFS_TRIG, tg);
		wr(dbt_pkg::OFS_CTRL, 8'hc0);
		wr(dbt_pkg::OFS_TRIG, ~tg);
		rchk(dbt_pkg::OFS_TRIG, tg & dbt_pkg::TRIG_WR_MASK);
		repeat (8 + xs() % 4) acc(qv[i], i == 7 ? 1'b0 : 1'(xs()));
		rchk(dbt_pkg::OFS_STATUS, 8'h20, 8'h20);
		acc(pv[i], 1'b1);
		acc(fv[i], 1'b1);
		rchk(dbt_pkg::OFS_STATUS, st(md[i] == 0, md[i] == 1, 0, 8), i < 2 || i == 7 ? 8'hef : 8'h2f);
	endtask : end_run

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int i;
		int j;
		{aresetn, mcu_secure, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(dbt_pkg::OFS_STATUS, 8'h00);
		rchk(dbt_pkg::OFS_TRIG, dbt_pkg::TRIG_RESET);
		wr(5'h14, 8'hff);
		rchk(5'h14, 8'h00);
		wr(dbt_pkg::OFS_TRIG, 8'hff);
		rchk(dbt_pkg::OFS_TRIG, 8'hff & dbt_pkg::TRIG_WR_MASK);
		wr(dbt_pkg::OFS_STATUS, 8'hff);
		rchk(dbt_pkg::OFS_STATUS, 8'h00);
		mcu_secure <= 1'b1;
		wr(dbt_pkg::OFS_CTRL, 8'h80);
		rchk(dbt_pkg::OFS_CTRL, 8'h00, 8'h80);
		mcu_secure <= 1'b0;
		for (i = 0; i < 8; i++)
			end_run(i);
		// begin trace: eight stored words after the trigger fill storage
		wr(dbt_pkg::OFS_TRIG, 8'h41);
		wr(dbt_pkg::OFS_CTRL, 8'hf0);
		repeat (3 + xs() % 6) acc(5'h00, 1'(xs()));
		acc(5'h08, 1'b1);
		repeat (7) acc(5'h00, 1'(xs()));
		rchk(dbt_pkg::OFS_STATUS, 8'h20, 8'h20);
		check("break tag", cpu_break_tag, 1'b1);
		acc(5'h00, 1'b1);
		rchk(dbt_pkg::OFS_STATUS, st(0, 1, 0, 8), 8'hef);
		wr(dbt_pkg::OFS_STATUS, 8'h00);
		rchk(dbt_pkg::OFS_STATUS, st(0, 1, 0, 8), 8'hef);
		check("breaks", breaks, 1);
		rchk(dbt_pkg::OFS_TRIG, 8'h41);
		// event-only modes with the begin bit clear still run as begin traces
		for (j = 3; j <= 4; j++) begin
			wr(dbt_pkg::OFS_TRIG, 8'(j));
			wr(dbt_pkg::OFS_CTRL, 8'hc0);
			if (j == 4) begin
				acc(5'h08, 1'b1);
				acc(5'h10, 1'b1);
			end
			repeat (7) begin
				acc(5'h08, 1'b1);
				acc(5'h00, 1'b1);
			end
			rchk(dbt_pkg::OFS_STATUS, 8'h20, 8'h20);
			acc(5'h08, 1'b1);
			rchk(dbt_pkg::OFS_STATUS, st(0, 0, 0, 8), 8'h2f);
			rchk(dbt_pkg::OFS_FIFO_H, 8'h00);
			repeat (3) rd(dbt_pkg::OFS_FIFO_L);
			rchk(dbt_pkg::OFS_STATUS, st(0, 0, 0, 8), 8'h2f);
		end
		// codes without a trigger, then a manual stop by arm or by enable
		for (j = 0; j < 2; j++) begin
			wr(dbt_pkg::OFS_TRIG, 8'h09 + 8'(xs() % 7));
			wr(dbt_pkg::OFS_CTRL, 8'hc0);
			repeat (3) begin
				acc(5'h1f, 1'b1);
				acc(5'h10, 1'b1);
				acc(5'h08, 1'b1);
				acc(5'h00, 1'b1);
			end
			rchk(dbt_pkg::OFS_STATUS, 8'h20, 8'h20);
			wr(dbt_pkg::OFS_CTRL, j == 0 ? 8'h80 : 8'h40);
			rchk(dbt_pkg::OFS_STATUS, 8'h00, 8'h20);
		end
		// reset in mid-run clears flags and count
		wr(dbt_pkg::OFS_CTRL, 8'hc0);
		repeat (2) acc(5'h18, 1'b1);
		rchk(dbt_pkg::OFS_STATUS, 8'he2, 8'hef);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(dbt_pkg::OFS_STATUS, 8'h00);
		rchk(dbt_pkg::OFS_TRIG, dbt_pkg::TRIG_RESET);
		finish_test();
	end
endmodule : dbt_top_bench
